// *** rtl/mpcs_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock
// Notes:   Included by the top module only
`ifndef MPCS_DEFS_SVH
`define MPCS_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define MPCS_OFS_CTRL      8'h00
`define MPCS_OFS_LINK      8'h04
`define MPCS_OFS_PINS      8'h08
`define MPCS_OFS_STAT      8'h0C
`define MPCS_OFS_MASK      8'h10
`define MPCS_OFS_PINCMD    8'h14
`define MPCS_OFS_ID        8'h18

// ==========================================================
// Field positions
`define MPCS_CTRL_GPEN     0
`define MPCS_PINS_RTS      0
`define MPCS_PINS_CS       1
`define MPCS_ST_CHG        0
`define MPCS_ST_RDRSP      1

// ==========================================================
// Reset values
`define MPCS_CLKSRC_RST    2'h0
`define MPCS_RTS_RST       1'b1
// Identity word: arbitrary value
`define MPCS_ID_VALUE      32'h0000A5C3

// ==========================================================
// Timing
`define MPCS_CLK_HZ        25000000
`define MPCS_TICK_MS       8
`define MPCS_TICK_CYC      ((`MPCS_CLK_HZ / 1000) * `MPCS_TICK_MS)
`define MPCS_DIV16         16

`endif

// *** rtl/mpcs_pkg.sv ***
// Purpose: Types for the modem pin and serial clock select block
// Assumes: mpcs_defs.svh holds the numbers
// Notes:   Types only
package mpcs_pkg;

	typedef enum logic [1:0] {
		MPCS_SRC_EXT  = 2'h0,
		MPCS_SRC_RCLK = 2'h1,
		MPCS_SRC_SYS  = 2'h2,
		MPCS_SRC_RSV  = 2'h3
	} mpcs_clksrc_t;

	typedef enum logic [2:0] {
		MPCS_DB_IDLE  = 3'h1,
		MPCS_DB_SEEN  = 3'h2,
		MPCS_DB_ONCE  = 3'h4
	} mpcs_db_state_t;

endpackage

// *** rtl/mpcs_top.sv ***
// Purpose: Modem control pins, carrier sense debounce, tx clock source
// Assumes: 25 MHz mclk_i; pins and link clock are asynchronous inputs
// Notes:   Register map over a plain strobe port, read data next cycle
//
// Summary of operation
// - Request-to-send output changes only on the pin write command.
// - Pin read command returns request-to-send and carrier sense levels.
// - With pin support enabled, each carrier sense change raises status.
// - Sample every 8 ms; accept change after two confirming samples.
// - Sampling timer runs on system clock, not on serial clocks.
// - Clock source 01 or 10 drives tx clock at 1/16 of rx or system.
// - Clock source resets to 00; tx clock pin is then an input.
// - Source 01: rx clock is the 16x reference for the PLL; source 10: system clock is.
// - Source 00: rx clock is the 1x receive bit clock.
// - In reset: data and rts high, strobes low, bus pins floating.
// - After reset release, pins keep their reset state until changed.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "mpcs_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module mpcs_top
	import mpcs_pkg::*;
#(
	parameter int unsigned TICK_CYC = `MPCS_TICK_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o,
	input  wire logic        carrier_sense_in_i,
	output logic             request_to_send_o,
	input  wire logic        tx_bit_clock_pin_i,
	output logic             tx_bit_clock_pin_o,
	output logic             tx_bit_clock_pin_oe_o,
	input  wire logic        rx_bit_clock_pin_i,
	output logic             rx_bit_clk_en_o,
	output logic             dpll_ref_en_o,
	output logic             tx_bit_clk_en_o,
	output logic             tx_data_o,
	output logic             bus_hold_request_o,
	output logic             address_latch_strobe_o,
	output logic             upper_address_enable_o,
	output logic             bus_float_o
);

	// ==========================================================
	// Helpers
	function automatic logic is_div_src(input logic [1:0] s);
		is_div_src = (s == MPCS_SRC_RCLK) || (s == MPCS_SRC_SYS);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// ==========================================================
	// Input synchronisers
	logic [1:0] cs_sync;
	logic [1:0] rck_sync;
	logic [1:0] tck_sync;
	logic       rck_prev;
	logic       tck_prev;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_sync  <= 2'h0;
			rck_sync <= 2'h0;
			tck_sync <= 2'h0;
			rck_prev <= 1'b0;
			tck_prev <= 1'b0;
		end else begin
			cs_sync  <= {cs_sync[0], carrier_sense_in_i};
			rck_sync <= {rck_sync[0], rx_bit_clock_pin_i};
			tck_sync <= {tck_sync[0], tx_bit_clock_pin_i};
			rck_prev <= rck_sync[1];
			tck_prev <= tck_sync[1];
		end
	end

	logic rck_rise;
	logic tck_rise;
	assign rck_rise = rck_sync[1] & ~rck_prev;
	assign tck_rise = tck_sync[1] & ~tck_prev;

	// ==========================================================
	// Control registers
	logic        gp_pin_support_enable;
	logic [1:0]  clk_src;
	logic [1:0]  stat;
	logic [1:0]  mask;
	logic        cs_level;
	logic        chg_evt;
	logic        rdrsp_evt;
	logic [1:0]  rdrsp_pins;
	logic        wr_ctrl;
	logic        wr_pincmd;

	assign wr_ctrl   = wr_i && hit(addr_i, `MPCS_OFS_CTRL);
	assign wr_pincmd = wr_i && hit(addr_i, `MPCS_OFS_PINCMD);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gp_pin_support_enable <= 1'b0;
			clk_src               <= `MPCS_CLKSRC_RST;
			mask                  <= 2'h0;
		end else if (wr_i) begin
			if (wr_ctrl)
				gp_pin_support_enable <= wdata_i[`MPCS_CTRL_GPEN];
			if (hit(addr_i, `MPCS_OFS_LINK))
				clk_src <= wdata_i[1:0];
			if (hit(addr_i, `MPCS_OFS_MASK))
				mask <= wdata_i[1:0];
		end
	end

	// Write 1 bit 0 of pin command = rts write, bit 1 = pin read command
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			request_to_send_o <= `MPCS_RTS_RST;
		end else if (wr_pincmd && wdata_i[0]) begin
			request_to_send_o <= wdata_i[8];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdrsp_evt  <= 1'b0;
			rdrsp_pins <= 2'h0;
		end else begin
			rdrsp_evt <= wr_pincmd && wdata_i[1];
			if (wr_pincmd && wdata_i[1])
				rdrsp_pins <= {cs_level, request_to_send_o};
		end
	end

	// ==========================================================
	// 8 ms tick from the system clock, so it runs with serial clocks stopped
	logic [31:0] tick_cnt;
	logic        tick;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt <= 32'h0;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_CYC - 1) begin
			tick_cnt <= 32'h0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
			tick     <= 1'b0;
		end
	end

	// ==========================================================
	// Carrier sense debounce: change seen, then two confirming samples
	mpcs_db_state_t db_state;
	logic           cs_first;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			db_state <= MPCS_DB_IDLE;
			cs_first <= 1'b0;
			cs_level <= 1'b0;
			chg_evt  <= 1'b0;
		end else begin
			chg_evt <= 1'b0;
			if (!cs_first) begin
				// Take the level after the first tick, no false change
				if (tick) begin
					cs_first <= 1'b1;
					cs_level <= cs_sync[1];
				end
			end else if (tick) begin
				case (db_state)
				MPCS_DB_IDLE: begin
					if (cs_sync[1] != cs_level)
						db_state <= MPCS_DB_SEEN;
				end
				MPCS_DB_SEEN: begin
					db_state <= (cs_sync[1] != cs_level) ?
						MPCS_DB_ONCE : MPCS_DB_IDLE;
				end
				MPCS_DB_ONCE: begin
					db_state <= MPCS_DB_IDLE;
					if (cs_sync[1] != cs_level) begin
						cs_level <= cs_sync[1];
						chg_evt  <= gp_pin_support_enable;
					end
				end
				default: db_state <= MPCS_DB_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Sticky status, set wins over write-one-to-clear
	logic [1:0] stat_set;
	logic [1:0] stat_clr;
	assign stat_set = {rdrsp_evt, chg_evt};
	assign stat_clr = (wr_i && hit(addr_i, `MPCS_OFS_STAT)) ?
		wdata_i[1:0] : 2'h0;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat  <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			stat  <= (stat & ~stat_clr) | stat_set;
			irq_o <= |(((stat & ~stat_clr) | stat_set) & mask);
		end
	end

	// ==========================================================
	// Serial clock selection and divide by 16
	logic [3:0] div_cnt;
	logic       div_src_edge;

	always_comb begin
		case (clk_src)
		MPCS_SRC_RCLK: div_src_edge = rck_rise;
		MPCS_SRC_SYS:  div_src_edge = 1'b1;
		default:       div_src_edge = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt               <= 4'h0;
			tx_bit_clock_pin_o    <= 1'b0;
			tx_bit_clock_pin_oe_o <= 1'b0;
			tx_bit_clk_en_o       <= 1'b0;
			rx_bit_clk_en_o       <= 1'b0;
			dpll_ref_en_o         <= 1'b0;
		end else begin
			tx_bit_clock_pin_oe_o <= is_div_src(clk_src);
			dpll_ref_en_o   <= is_div_src(clk_src) & div_src_edge;
			rx_bit_clk_en_o <= !is_div_src(clk_src) & rck_rise;
			if (is_div_src(clk_src)) begin
				if (div_src_edge) begin
					div_cnt            <= div_cnt + 4'h1;
					tx_bit_clock_pin_o <= div_cnt[3];
				end
				tx_bit_clk_en_o <= div_src_edge && (div_cnt == 4'hF);
			end else begin
				div_cnt            <= 4'h0;
				tx_bit_clock_pin_o <= 1'b0;
				tx_bit_clk_en_o    <= tck_rise;
			end
		end
	end

	// ==========================================================
	// Pins owned by other blocks keep reset levels here
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_data_o              <= 1'b1;
			bus_hold_request_o     <= 1'b0;
			address_latch_strobe_o <= 1'b0;
			upper_address_enable_o <= 1'b0;
			bus_float_o            <= 1'b1;
		end else begin
			tx_data_o              <= 1'b1;
			bus_hold_request_o     <= 1'b0;
			address_latch_strobe_o <= 1'b0;
			upper_address_enable_o <= 1'b0;
			bus_float_o            <= 1'b1;
		end
	end

	// ==========================================================
	// Read port, data valid in the cycle after the strobe only
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0;
		case (addr_i)
		`MPCS_OFS_CTRL:   next_rdata = {31'h0, gp_pin_support_enable};
		`MPCS_OFS_LINK:   next_rdata = {30'h0, clk_src};
		`MPCS_OFS_PINS:   next_rdata = {28'h0, rdrsp_pins,
			cs_level, request_to_send_o};
		`MPCS_OFS_STAT:   next_rdata = {30'h0, stat};
		`MPCS_OFS_MASK:   next_rdata = {30'h0, mask};
		`MPCS_OFS_ID:     next_rdata = `MPCS_ID_VALUE; // Arbitrary value
		default:          next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_o <= 32'h0;
		else
			rdata_o <= rd_i ? next_rdata : 32'h0;
	end

endmodule

`default_nettype wire

// *** sim/mpcs_asserts.sv ***
// Purpose: Port checks on the modem pin and clock select block
// Assumes: Strobe port, read data one cycle after the read strobe
// Notes:   Bound into mpcs_top below
`timescale 1ns/1ns
`default_nettype none
module mpcs_asserts (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        request_to_send_o,
	input wire logic        tx_bit_clock_pin_o,
	input wire logic        tx_bit_clock_pin_oe_o,
	input wire logic        rx_bit_clk_en_o,
	input wire logic        dpll_ref_en_o,
	input wire logic        tx_data_o,
	input wire logic        bus_hold_request_o,
	input wire logic        address_latch_strobe_o,
	input wire logic        upper_address_enable_o,
	input wire logic        bus_float_o
);
	logic [1:0] src;
	logic       rts_wr;
	assign rts_wr = wr_i && addr_i == 8'h14 && wdata_i[0];
	// Own copy of the source field, so no hierarchy peeking is needed
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			src <= 2'h0;
		else if (wr_i && addr_i == 8'h04)
			src <= wdata_i[1:0];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Leaving source 10 may cut a half period short, so it is excused
	sequence s_half_sys;
		(!$changed(tx_bit_clock_pin_o) || src != 2'h2) [*7]
		##1 ($changed(tx_bit_clock_pin_o) || src != 2'h2);
	endsequence
	chk_rts_hold: assert property (
		!rts_wr |=> $stable(request_to_send_o)) else $error("rts moved");
	chk_rts_write: assert property (
		rts_wr |=> request_to_send_o == $past(wdata_i[8]))
		else $error("rts not written");
	chk_reset_pins: assert property (
		tx_data_o && bus_float_o && !bus_hold_request_o
		&& !address_latch_strobe_o && !upper_address_enable_o)
		else $error("idle pin level wrong");
	chk_oe_write: assert property (
		wr_i && addr_i == 8'h04 |=> ##1 tx_bit_clock_pin_oe_o
		== (src == 2'h1 || src == 2'h2)) else $error("tx pin drive wrong");
	chk_sys_div: assert property (
		src == 2'h2 && $changed(tx_bit_clock_pin_o) |=> s_half_sys)
		else $error("tx clock not 1/16");
	chk_clk_excl: assert property (
		rx_bit_clk_en_o |-> !dpll_ref_en_o) else $error("both rx uses");
	chk_rdata_idle: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0) else $error("stray read data");
	chk_pins_read: assert property (
		rd_i && addr_i == 8'h08 |=> rdata_o[0] == $past(request_to_send_o))
		else $error("pin read wrong");
endmodule
// Enable is registered from the field, so it trails the write by two cycles
bind mpcs_top mpcs_asserts chk_u (
	.mclk_i                 (mclk_i),
	.rst_n_i                (rst_n_i),
	.addr_i                 (addr_i),
	.wdata_i                (wdata_i),
	.wr_i                   (wr_i),
	.rd_i                   (rd_i),
	.rdata_o                (rdata_o),
	.request_to_send_o      (request_to_send_o),
	.tx_bit_clock_pin_o     (tx_bit_clock_pin_o),
	.tx_bit_clock_pin_oe_o  (tx_bit_clock_pin_oe_o),
	.rx_bit_clk_en_o        (rx_bit_clk_en_o),
	.dpll_ref_en_o          (dpll_ref_en_o),
	.tx_data_o              (tx_data_o),
	.bus_hold_request_o     (bus_hold_request_o),
	.address_latch_strobe_o (address_latch_strobe_o),
	.upper_address_enable_o (upper_address_enable_o),
	.bus_float_o            (bus_float_o)
);
`default_nettype wire

// *** sim/mpcs_modem_model.sv ***
// Purpose: Modem side: carrier line and receive bit clock
// Assumes: Receive clock period 320 ns
// Notes:   Clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module mpcs_modem_model (
	input  wire logic run_i,
	input  wire logic cs_level_i,
	output logic      carrier_sense_o,
	output logic      rx_clk_o
);
	assign carrier_sense_o = cs_level_i;
	// Odd offset keeps edges away from system clock edges
	initial begin
		rx_clk_o = 1'b0;
		#7;
		forever #160 rx_clk_o = run_i ? ~rx_clk_o : 1'b0;
	end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the modem pin block
// Assumes: Carrier tick shortened through TICK_CYC
// Notes:   Random pin values from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int TK = 20;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        run = 1'b0, cs_lvl = 1'b1, pt;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic        irq, cs, rts, txo, txoe, rck, rxen, dpll, txen;
	wire logic [4:0] idle;
	wire logic   tx_pin = txoe ? txo : rck;
	int          fail_count = 0, checks_done = 0, i, m, v, nr, nd, nt, ne;
	always #20 clk = ~clk;
	mpcs_modem_model mdl_u (.run_i(run), .cs_level_i(cs_lvl),
		.carrier_sense_o(cs), .rx_clk_o(rck));
	mpcs_top #(.TICK_CYC(TK)) dut_u (.mclk_i(clk), .rst_n_i(rst_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .irq_o(irq), .carrier_sense_in_i(cs),
		.request_to_send_o(rts), .tx_bit_clock_pin_i(tx_pin),
		.tx_bit_clock_pin_o(txo), .tx_bit_clock_pin_oe_o(txoe),
		.rx_bit_clock_pin_i(rck), .rx_bit_clk_en_o(rxen),
		.dpll_ref_en_o(dpll), .tx_bit_clk_en_o(txen),
		.tx_data_o(idle[4]), .bus_hold_request_o(idle[3]),
		.address_latch_strobe_o(idle[2]),
		.upper_address_enable_o(idle[1]), .bus_float_o(idle[0]));
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] x);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] k, e,
		input string nm);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(nm, rdata & k, e);
		@(posedge clk);
	endtask
	task automatic wirq(input logic lv, input int n);
		for (int k = 0; k < n && irq !== lv; k++)
			@(negedge clk);
		chk("irq", irq, lv);
		if (irq !== lv)
			results();
		@(posedge clk);
	endtask
	// Pulse counts over 256 cycles: rx 1x, reference, tx pin, tx enable
	function automatic int exp_n(input int m, k);
		int e[4] = '{32, 0, 0, 32};
		if (m == 1)
			e = '{0, 32, 4, 2};
		if (m == 2)
			e = '{0, 256, 32, 16};
		return e[k];
	endfunction
	function automatic logic near(input int a, b);
		return a - b <= 1 && b - a <= 1;
	endfunction
	initial begin
		void'($urandom(77));
		repeat (5) @(posedge clk);
		chk("rts in reset", rts, 1);
		chk("tx pin in reset", txoe, 0);
		chk("irq in reset", irq, 0);
		chk("idle pins in reset", idle, 5'h11);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("rts after reset", rts, 1);
		rdc(8'h04, 32'h3, 0, "clock source");
		rdc(8'h1C, 32'hFFFFFFFF, 0, "unmapped");
		$display("reset test done");
		for (i = 0; i < 6; i++) begin
			v = $urandom;
			wrr(8'h14, {23'h0, v[0], 7'h0, 1'b1});
			rdc(8'h08, 32'h1, v[0], "rts written");
			wrr(8'h14, {23'h0, ~v[0], 8'h0});
			rdc(8'h08, 32'h1, v[0], "rts held");
		end
		wrr(8'h10, 32'h2);
		wrr(8'h14, 32'h2);
		wirq(1'b1, 8);
		rdc(8'h08, 32'hC, {cs_lvl, v[0], 2'h0}, "pin snapshot");
		wrr(8'h0C, 32'h2);
		wirq(1'b0, 4);
		$display("pin test done");
		wrr(8'h10, 32'h1);
		cs_lvl <= 1'b0;
		repeat (4 * TK) @(posedge clk);
		rdc(8'h0C, 32'h1, 0, "event while off");
		rdc(8'h08, 32'h2, 0, "carrier level");
		wrr(8'h00, 32'h1);
		cs_lvl <= 1'b1;
		repeat (30) @(posedge clk);
		cs_lvl <= 1'b0;
		repeat (4 * TK) @(posedge clk);
		rdc(8'h0C, 32'h1, 0, "short pulse");
		cs_lvl <= 1'b1;
		repeat (40) @(posedge clk);
		chk("irq early", irq, 0);
		wirq(1'b1, 2 * TK);
		rdc(8'h08, 32'h2, 32'h2, "carrier level");
		wrr(8'h0C, 32'h1);
		wirq(1'b0, 4);
		wrr(8'h10, 32'h0);
		cs_lvl <= 1'b0;
		repeat (4 * TK) @(posedge clk);
		chk("irq masked", irq, 0);
		rdc(8'h0C, 32'h1, 1, "masked event");
		$display("carrier test done");
		run <= 1'b1;
		for (m = 0; m < 4; m++) begin
			wrr(8'h04, m);
			repeat (16) @(posedge clk);
			chk("tx pin drive", txoe, m == 1 || m == 2);
			nr = 0;
			nd = 0;
			nt = 0;
			ne = 0;
			pt = txo;
			for (i = 0; i < 256; i++) begin
				@(negedge clk);
				nr += (rxen !== 1'b0);
				nd += (dpll !== 1'b0);
				ne += (txen !== 1'b0);
				nt += (txo !== pt);
				pt = txo;
			end
			chk("rx 1x pulses", near(nr, exp_n(m, 0)), 1);
			chk("pll pulses", near(nd, exp_n(m, 1)), 1);
			chk("tx enables", near(ne, exp_n(m, 3)), 1);
			if (m == 1 || m == 2)
				chk("tx toggles", near(nt, exp_n(m, 2)), 1);
			@(posedge clk);
		end
		run <= 1'b0;
		$display("clock test done");
		wrr(8'h14, 32'h1);
		wrr(8'h04, 32'h2);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("rts reset", rts, 1);
		chk("tx pin reset", txoe, 0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("rts kept", rts, 1);
		chk("tx pin kept", txoe, 0);
		chk("idle pins kept", idle, 5'h11);
		$display("second reset test done");
		results();
	end
endmodule
`default_nettype wire
